// ---- include/smci_pkg.sv ----
// constants and types shared by the two-wire client interface
package smci_pkg;

  // ==========================================================
  // clock and bus timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint SCL_LOW_TIMEOUT_MS = 30;
  localparam longint BUS_IDLE_TIMEOUT_US = 200;
  // least times: round up to whole cycles
  localparam longint SCL_LOW_TIMEOUT_CYC = (SCL_LOW_TIMEOUT_MS * CLK_HZ + 999) / 1000;
  localparam longint BUS_IDLE_TIMEOUT_CYC = (BUS_IDLE_TIMEOUT_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int TIMEOUT_CNT_W = 22;

  // ==========================================================
  // byte framing
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam int ADDR_W = 7;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // ==========================================================
  // address strap decode, code F means strap left open
  localparam int STRAP_W = 4;
  localparam logic [ADDR_W-1:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [ADDR_W-1:0] CLIENT_ADDR_TABLE [0:15] = '{
    7'h4C, 7'h4D, 7'h4E, 7'h4F, 7'h48, 7'h49, 7'h4A, 7'h4B,
    7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h18
  };

  // ==========================================================
  // client state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_RD_ACK = 3'b110
  } smci_state_t;

endpackage

// ---- include/smci_line_if.sv ----
// cleaned line levels and bus events passed from the line sampler to the client
`timescale 1ns/1ps
`default_nettype none
interface smci_line_if;
  logic sclLevel;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  modport src (output sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
  modport snk (input sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
endinterface
`default_nettype wire

// ---- design/smci_line_sync.sv ----
// pin sampler: three-stage synchronisers, agreement filter, edge and start/stop events
`timescale 1ns/1ps
`default_nettype none
module smci_line_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  smci_line_if.src ln
);
  // ==========================================================
  // synchronisers, bit 0 = clock line, bit 1 = data line
  logic [1:0] pinRaw;
  logic [1:0] stage1_reg;
  logic [1:0] stage2_reg;
  logic [1:0] stage3_reg;
  logic [1:0] level_reg;
  logic [1:0] levelPrev_reg;

  assign pinRaw = {sdaIn, sclIn};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1_reg[i] <= 1'b1;
          stage2_reg[i] <= 1'b1;
          stage3_reg[i] <= 1'b1;
          level_reg[i] <= 1'b1;
          levelPrev_reg[i] <= 1'b1;
        end else begin
          stage1_reg[i] <= pinRaw[i]; // R11
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          // a change counts only once two later stages agree
          if (stage2_reg[i] == stage3_reg[i]) begin
            level_reg[i] <= stage3_reg[i];
          end
          levelPrev_reg[i] <= level_reg[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // events
  assign ln.sclLevel = level_reg[0];
  assign ln.sdaLevel = level_reg[1];
  assign ln.sclRise = level_reg[0] & ~levelPrev_reg[0];
  assign ln.sclFall = ~level_reg[0] & levelPrev_reg[0];
  // data edges only mean start/stop while the clock stays high
  assign ln.startSeen = ~level_reg[1] & levelPrev_reg[1] & level_reg[0] & levelPrev_reg[0]; // R1
  assign ln.stopSeen = level_reg[1] & ~levelPrev_reg[1] & level_reg[0] & levelPrev_reg[0]; // R7
endmodule
`default_nettype wire

// ---- design/smci_client.sv ----
// two-wire client interface: address match, byte transfer, acknowledge, timeouts
// ==========================================================
// Summary of operation
// (R1) Data falling while clock high is a start; address decoding begins.
// (R2) First byte: seven address bits, then direction, 0 write, 1 read.
// (R3) Own address picked from sixteen choices by the strap code.
// (R4) Bytes are eight bits, most significant bit first, both directions.
// (R5) Acknowledge own address, every written byte, and alert address on alert; code acks the alert address on reads only.
// (R6) Host ends a read by leaving data high after its last byte.
// (R7) Data rising while clock high is a stop; machine returns to idle.
// (R8) With timeouts enabled, clock low over 30 ms resets the client.
// (R9) Timeout enable is cleared by reset.
// (R10) With timeouts enabled, both lines high over 200 us reset the client.
// (R11) Works for serial clock rates 10 kHz to 400 kHz.
// (R12) Plain multi-byte framing, no count byte, any number of bytes.
// (R13) Device never drives the clock line; host stretching is tolerated.
// (R14) Write of a register address alone loads the register pointer.
// (R15) Multi-byte transfers walk contiguous registers from the given address.
// (R16) On alert, alert response read returns own address; else no response.
// (R17) After sending full address without losing contention, pulse alert mask set.
// (R18) Pointer advances by one after each transferred data byte.
`timescale 1ns/1ps
`default_nettype none
module smci_client #(
  parameter longint LOW_TIMEOUT_CYC = smci_pkg::SCL_LOW_TIMEOUT_CYC,
  parameter longint IDLE_TIMEOUT_CYC = smci_pkg::BUS_IDLE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serialClockLineIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [smci_pkg::STRAP_W-1:0] addrStrap,
  input wire logic alertActive,
  input wire logic timeoutEnable,
  input wire logic [smci_pkg::BYTE_W-1:0] regRdData,
  output logic [smci_pkg::BYTE_W-1:0] regPtr,
  output logic [smci_pkg::BYTE_W-1:0] regWrAddr,
  output logic [smci_pkg::BYTE_W-1:0] regWrData,
  output logic regWrStrobe,
  output logic regRdStrobe,
  output logic alertMaskSet,
  output logic busy
);
  import smci_pkg::*;

  localparam logic [TIMEOUT_CNT_W-1:0] LOW_LIMIT = TIMEOUT_CNT_W'(LOW_TIMEOUT_CYC);
  localparam logic [TIMEOUT_CNT_W-1:0] IDLE_LIMIT = TIMEOUT_CNT_W'(IDLE_TIMEOUT_CYC);

  // ==========================================================
  // line sampler
  smci_line_if ln ();

  smci_line_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .sclIn(serialClockLineIn),
    .sdaIn(sdaIn),
    .ln(ln)
  );

  // ==========================================================
  // strap capture and timeout enable
  logic strapLoaded_reg;
  logic [ADDR_W-1:0] ownAddr_reg;
  logic timeoutEn_reg;

  // strap is caught after reset release, never inside the reset branch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapLoaded_reg <= 1'b0;
      ownAddr_reg <= '0;
    end else if (!strapLoaded_reg) begin
      strapLoaded_reg <= 1'b1;
      ownAddr_reg <= CLIENT_ADDR_TABLE[addrStrap]; // R3
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeoutEn_reg <= 1'b0; // R9
    end else begin
      timeoutEn_reg <= timeoutEnable;
    end
  end

  // ==========================================================
  // inactivity timers
  logic [TIMEOUT_CNT_W-1:0] lowCnt_reg;
  logic [TIMEOUT_CNT_W-1:0] idleCnt_reg;
  logic timeoutHit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt_reg <= '0;
    end else if (!timeoutEn_reg || ln.sclLevel) begin
      lowCnt_reg <= '0;
    end else if (lowCnt_reg != LOW_LIMIT) begin
      lowCnt_reg <= lowCnt_reg + 1'b1; // R8
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idleCnt_reg <= '0;
    end else if (!timeoutEn_reg || !ln.sclLevel || !ln.sdaLevel) begin
      idleCnt_reg <= '0;
    end else if (idleCnt_reg != IDLE_LIMIT) begin
      idleCnt_reg <= idleCnt_reg + 1'b1; // R10
    end
  end

  // the limit is held until activity so the reset fires once per episode
  assign timeoutHit = (lowCnt_reg == LOW_LIMIT - 1'b1) || (idleCnt_reg == IDLE_LIMIT - 1'b1); // R8 R10

  // ==========================================================
  // client state machine
  smci_state_t state_reg;
  logic [BIT_CNT_W-1:0] bitCnt_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic isRead_reg;
  logic isAlertResp_reg;
  logic matched_reg;
  logic firstWrByte_reg;
  logic hostAck_reg;
  logic [BYTE_W-1:0] ptr_reg;
  logic sdaOe_reg;
  logic wrStrobe_reg;
  logic rdStrobe_reg;
  logic maskSet_reg;
  logic [BYTE_W-1:0] wrAddr_reg;
  logic [BYTE_W-1:0] wrData_reg;
  logic [ADDR_W-1:0] rxAddr;
  logic byteDone;

  assign rxAddr = shift_reg[BYTE_W-1:1];
  assign byteDone = (bitCnt_reg == BITS_PER_BYTE);

  // the clock line has no driver at all, so the client never stretches; host stretching is tolerated
  always_ff @(posedge clk or negedge arst_n) begin // R13
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= '0;
      shift_reg <= '0;
      isRead_reg <= 1'b0;
      isAlertResp_reg <= 1'b0;
      matched_reg <= 1'b0;
      firstWrByte_reg <= 1'b0;
      hostAck_reg <= 1'b0;
      ptr_reg <= '0;
      sdaOe_reg <= 1'b0;
      wrStrobe_reg <= 1'b0;
      rdStrobe_reg <= 1'b0;
      maskSet_reg <= 1'b0;
      wrAddr_reg <= '0;
      wrData_reg <= '0;
    end else begin
      wrStrobe_reg <= 1'b0;
      rdStrobe_reg <= 1'b0;
      maskSet_reg <= 1'b0;
      if (ln.startSeen) begin
        // a repeated start is taken from any state
        state_reg <= ST_ADDR; // R1
        bitCnt_reg <= '0;
        sdaOe_reg <= 1'b0;
        // busy must not carry over from an earlier, addressed transfer
        matched_reg <= 1'b0;
        firstWrByte_reg <= 1'b1;
      end else if (ln.stopSeen || timeoutHit) begin
        state_reg <= ST_IDLE; // R7 R8 R10
        sdaOe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (ln.sclRise && !byteDone) begin
              shift_reg <= {shift_reg[BYTE_W-2:0], ln.sdaLevel}; // R4
              bitCnt_reg <= bitCnt_reg + 1'b1;
            end else if (ln.sclFall && byteDone) begin
              isRead_reg <= (shift_reg[0] == DIR_READ); // R2
              isAlertResp_reg <= (rxAddr == ALERT_RESP_ADDR);
              if (rxAddr == ownAddr_reg
                  || (rxAddr == ALERT_RESP_ADDR && alertActive && shift_reg[0] == DIR_READ)) begin
                matched_reg <= 1'b1;
                sdaOe_reg <= 1'b1; // R5 R16
                state_reg <= ST_ADDR_ACK;
              end else begin
                matched_reg <= 1'b0;
                state_reg <= ST_IDLE; // R16
              end
            end
          end
          ST_ADDR_ACK: begin
            if (ln.sclFall) begin
              bitCnt_reg <= '0;
              if (isRead_reg) begin
                state_reg <= ST_RD_BYTE;
                if (isAlertResp_reg && rxAddr != ownAddr_reg) begin
                  shift_reg <= {ownAddr_reg, 1'b0}; // R16
                  sdaOe_reg <= ~ownAddr_reg[ADDR_W-1];
                end else begin
                  shift_reg <= regRdData; // R15
                  sdaOe_reg <= ~regRdData[BYTE_W-1];
                  rdStrobe_reg <= 1'b1;
                  isAlertResp_reg <= 1'b0;
                end
              end else begin
                state_reg <= ST_WR_BYTE;
                sdaOe_reg <= 1'b0;
              end
            end
          end
          ST_WR_BYTE: begin
            if (ln.sclRise && !byteDone) begin
              shift_reg <= {shift_reg[BYTE_W-2:0], ln.sdaLevel}; // R4
              bitCnt_reg <= bitCnt_reg + 1'b1;
            end else if (ln.sclFall && byteDone) begin
              sdaOe_reg <= 1'b1; // R5
              state_reg <= ST_WR_ACK;
              if (firstWrByte_reg) begin
                firstWrByte_reg <= 1'b0;
                ptr_reg <= shift_reg; // R14
              end else begin
                wrStrobe_reg <= 1'b1; // R12
                wrAddr_reg <= ptr_reg;
                wrData_reg <= shift_reg;
                ptr_reg <= ptr_reg + 1'b1; // R18
              end
            end
          end
          ST_WR_ACK: begin
            if (ln.sclFall) begin
              sdaOe_reg <= 1'b0;
              bitCnt_reg <= '0;
              state_reg <= ST_WR_BYTE; // R12
            end
          end
          ST_RD_BYTE: begin
            if (ln.sclRise && !byteDone) begin
              bitCnt_reg <= bitCnt_reg + 1'b1;
              // released a one but the line reads low: another client won
              if (!sdaOe_reg && !ln.sdaLevel) begin
                state_reg <= ST_IDLE;
              end
            end else if (ln.sclFall) begin
              if (byteDone) begin
                sdaOe_reg <= 1'b0;
                state_reg <= ST_RD_ACK;
                if (isAlertResp_reg) begin
                  maskSet_reg <= 1'b1; // R17
                end else begin
                  ptr_reg <= ptr_reg + 1'b1; // R18
                end
              end else begin
                shift_reg <= {shift_reg[BYTE_W-2:0], 1'b0}; // R4
                sdaOe_reg <= ~shift_reg[BYTE_W-2];
              end
            end
          end
          ST_RD_ACK: begin
            if (ln.sclRise) begin
              hostAck_reg <= ~ln.sdaLevel;
            end else if (ln.sclFall) begin
              bitCnt_reg <= '0;
              if (hostAck_reg && !isAlertResp_reg) begin
                shift_reg <= regRdData; // R12 R15
                sdaOe_reg <= ~regRdData[BYTE_W-1];
                rdStrobe_reg <= 1'b1;
                state_reg <= ST_RD_BYTE;
              end else begin
                state_reg <= ST_IDLE; // R6
              end
            end
          end
          ST_IDLE: begin
            sdaOe_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
            sdaOe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // busy flag
  logic busy_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg != ST_IDLE) && matched_reg;
    end
  end

  // ==========================================================
  // outputs, open drain data: only ever pulls low
  logic sdaOut_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaOut_reg <= 1'b0;
    end else begin
      sdaOut_reg <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_reg;
  assign sdaOe = sdaOe_reg;
  assign regPtr = ptr_reg;
  assign regWrAddr = wrAddr_reg;
  assign regWrData = wrData_reg;
  assign regWrStrobe = wrStrobe_reg;
  assign regRdStrobe = rdStrobe_reg;
  assign alertMaskSet = maskSet_reg;
  assign busy = busy_reg;
endmodule
`default_nettype wire

// ---- sim/smci_checker.sv ----
// assertion checker for the two-wire client, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module smci_checker #(
  parameter longint LOW_TIMEOUT_CYC = smci_pkg::SCL_LOW_TIMEOUT_CYC,
  parameter longint IDLE_TIMEOUT_CYC = smci_pkg::BUS_IDLE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serialClockLineIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [smci_pkg::STRAP_W-1:0] addrStrap,
  input wire logic alertActive,
  input wire logic timeoutEnable,
  input wire logic [smci_pkg::BYTE_W-1:0] regRdData,
  input wire logic [smci_pkg::BYTE_W-1:0] regPtr,
  input wire logic [smci_pkg::BYTE_W-1:0] regWrAddr,
  input wire logic [smci_pkg::BYTE_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic alertMaskSet,
  input wire logic busy
);
  import smci_pkg::*;
  // ====
  // line timers, margin of 8 covers the pin synchronisers
  longint lowCnt;
  longint idleCnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt <= 0;
    end else begin
      lowCnt <= (timeoutEnable && !serialClockLineIn) ? lowCnt + 1 : 0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idleCnt <= 0;
    end else begin
      idleCnt <= (timeoutEnable && serialClockLineIn && sdaIn) ? idleCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ====
  // properties
  property p_sda_out_low; sdaOut == 1'b0; endproperty
  a_sda_out_low: assert property (p_sda_out_low)
    else $error("data output not low");
  property p_oe_clk_low; $changed(sdaOe) |-> !serialClockLineIn; endproperty
  a_oe_clk_low: assert property (p_oe_clk_low)
    else $error("data drive moved with clock high");
  property p_wr_ptr_step; regWrStrobe |=> regPtr == regWrAddr + 8'h01; endproperty
  a_wr_ptr_step: assert property (p_wr_ptr_step)
    else $error("pointer not one past write address");
  property p_wr_pulse; regWrStrobe |=> !regWrStrobe; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_rd_busy; regRdStrobe |-> busy ##1 !regRdStrobe; endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("read strobe outside transfer");
  property p_mask_pulse; alertMaskSet |-> busy ##1 !alertMaskSet; endproperty
  a_mask_pulse: assert property (p_mask_pulse)
    else $error("alert mask pulse malformed");
  property p_reset_quiet; $rose(arst_n) |-> !busy && !sdaOe && regPtr == 8'h00; endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
  property p_low_timeout; lowCnt == LOW_TIMEOUT_CYC + 8 |-> !busy && !sdaOe; endproperty
  a_low_timeout: assert property (p_low_timeout)
    else $error("clock low timeout missed");
  property p_idle_timeout; idleCnt == IDLE_TIMEOUT_CYC + 8 |-> !busy; endproperty
  a_idle_timeout: assert property (p_idle_timeout)
    else $error("idle timeout missed");
  c_write: cover property (regWrStrobe);
  c_read: cover property (regRdStrobe);
  c_mask: cover property (alertMaskSet);
endmodule
bind smci_client smci_checker #(
  .LOW_TIMEOUT_CYC(LOW_TIMEOUT_CYC),
  .IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC)
) smci_checker_inst (
  .clk(clk), .arst_n(arst_n), .serialClockLineIn(serialClockLineIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap), .alertActive(alertActive),
  .timeoutEnable(timeoutEnable), .regRdData(regRdData), .regPtr(regPtr),
  .regWrAddr(regWrAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .alertMaskSet(alertMaskSet), .busy(busy)
);
`default_nettype wire

// ---- sim/smci_host_model.sv ----
// behavioural two-wire host: open-drain lines with pull-ups, byte transfers
`timescale 1ns/1ps
`default_nettype none
module smci_host_model (
  input wire logic clk,
  input wire logic devOe,
  output logic sclLine,
  output logic sdaLine
);
  logic sclReg = 1'b1;
  logic sdaLow = 1'b0;
  logic odd = 1'b0;
  int lowCyc = 8;
  // pull-ups: a released line reads high
  assign sclLine = sclReg;
  assign sdaLine = !(sdaLow || devOe);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sdaLow <= 1'b0;
    tick(4);
    sclReg <= 1'b1;
    tick(6);
    sdaLow <= 1'b1;
    tick(6);
    sclReg <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    tick(lowCyc - 4);
    sclReg <= 1'b1;
    tick(6);
    sdaLow <= 1'b0;
    tick(6);
  endtask
  // data moves 4 cycles into the low phase, so it is steady around both clock edges
  task automatic slot(input logic b, output logic s);
    sdaLow <= !b;
    tick(lowCyc - 4);
    sclReg <= 1'b1;
    odd <= !odd;
    tick(odd ? 5 : 4);
    s = sdaLine;
    sclReg <= 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
    output logic ackOut);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(tx[i], s);
      rx[i] = s;
    end
    slot(ackIn, ackOut);
  endtask
endmodule
`default_nettype wire

// ---- sim/smbus_client_interface_tb_top.sv ----
// self-checking bench for the two-wire client with a host model
`timescale 1ns/1ps
`default_nettype none
module smbus_client_interface_tb_top;
  import smci_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [STRAP_W-1:0] addrStrap = 4'hF;
  logic alertActive = 1'b0;
  logic timeoutEnable = 1'b0;
  logic [BYTE_W-1:0] regRdData, regPtr, regWrAddr, regWrData;
  logic sdaOut, sdaOe, regWrStrobe, regRdStrobe, alertMaskSet, busy, sclLine, sdaLine;
  logic [7:0] mem [256];
  logic [6:0] own;
  int errors = 0;
  int tests_run = 0;
  int maskCnt = 0;
  always #5 clk = ~clk;
  // ====
  // register file stand-in
  assign regRdData = mem[regPtr];
  always @(posedge clk) begin
    if (regWrStrobe === 1'b1) mem[regWrAddr] <= regWrData;
    if (alertMaskSet === 1'b1) maskCnt <= maskCnt + 1;
  end
  smci_client #(.LOW_TIMEOUT_CYC(200), .IDLE_TIMEOUT_CYC(100)) smci_client_inst (
    .clk(clk), .arst_n(arst_n), .serialClockLineIn(sclLine), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap), .alertActive(alertActive),
    .timeoutEnable(timeoutEnable), .regRdData(regRdData), .regPtr(regPtr),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .alertMaskSet(alertMaskSet), .busy(busy)
  );
  smci_host_model smci_host_model_inst (.clk(clk), .devOe(sdaOe), .sclLine(sclLine),
    .sdaLine(sdaLine));
  // ====
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus_start();
    smci_host_model_inst.start();
  endtask
  task automatic bus_stop();
    smci_host_model_inst.stop();
  endtask
  task automatic wr(input logic [7:0] b, input logic expAck);
    logic [7:0] rx;
    logic ack;
    smci_host_model_inst.xfer(b, 1'b1, rx, ack);
    check(16'(ack), 16'(expAck));
  endtask
  task automatic rd(input logic nack, input logic [7:0] exp);
    logic [7:0] rx;
    logic ack;
    smci_host_model_inst.xfer(8'hFF, nack, rx, ack);
    check({8'h00, rx}, {8'h00, exp});
  endtask
  task automatic do_reset(input logic [3:0] code);
    addrStrap <= code;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    own = (code < 4'h8) ? {4'h9, code[2:0] ^ 3'h4} :
      (code == 4'hF) ? 7'h18 : {4'h5, code[2:0]};
  endtask
  // ====
  // scenarios
  task automatic t_strap();
    for (int c = 0; c < 16; c++) begin
      do_reset(4'(c));
      bus_start();
      wr({own, DIR_WRITE}, 1'b0);
      bus_stop();
      bus_start();
      wr({~own, DIR_WRITE}, 1'b1);
      bus_stop();
    end
    $display("strap test done");
  endtask
  task automatic t_write();
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    wr(8'h10, 1'b0);
    for (int i = 0; i < 3; i++) wr(8'hC0 + 8'(i), 1'b0);
    bus_stop();
    for (int i = 0; i < 3; i++) check({8'h00, mem[16 + i]}, 16'h00C0 + 16'(i));
    check({8'h00, regPtr}, 16'h0013);
    $display("block write test done");
  endtask
  task automatic t_read();
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    wr(8'h10, 1'b0);
    bus_start();
    wr({own, DIR_READ}, 1'b0);
    for (int i = 0; i < 3; i++) rd(i == 2, 8'hC0 + 8'(i));
    bus_stop();
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    wr(8'h40, 1'b0);
    bus_stop();
    bus_start();
    wr({own, DIR_READ}, 1'b0);
    rd(1'b1, 8'h1A);
    bus_stop();
    check({8'h00, regPtr}, 16'h0041);
    $display("read test done");
  endtask
  task automatic t_alert();
    logic [7:0] rx;
    logic ack;
    bus_start();
    wr({7'h0C, DIR_READ}, 1'b1);
    bus_stop();
    alertActive <= 1'b1;
    bus_start();
    wr({7'h0C, DIR_WRITE}, 1'b1);
    bus_start();
    wr({7'h0C, DIR_READ}, 1'b0);
    rd(1'b1, {own, 1'b0});
    bus_stop();
    check(16'(maskCnt), 16'h0001);
    // host holds data low where the device sends a one: contention lost, no mask
    bus_start();
    wr({7'h0C, DIR_READ}, 1'b0);
    smci_host_model_inst.xfer(8'h00, 1'b1, rx, ack);
    bus_stop();
    alertActive <= 1'b0;
    check({8'h00, rx}, 16'h0000);
    check(16'(maskCnt), 16'h0001);
    $display("alert test done");
  endtask
  task automatic t_stretch();
    smci_host_model_inst.lowCyc = 40;
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    wr(8'h20, 1'b0);
    wr(8'h3C, 1'b0);
    bus_stop();
    smci_host_model_inst.lowCyc = 8;
    check({8'h00, mem[32]}, 16'h003C);
    $display("stretch test done");
  endtask
  task automatic t_timeout();
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    repeat (300) @(posedge clk);
    check(16'(busy), 16'h0001);
    wr(8'h50, 1'b0);
    bus_stop();
    timeoutEnable <= 1'b1;
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    repeat (300) @(posedge clk);
    check(16'(busy), 16'h0000);
    wr(8'h50, 1'b1);
    bus_stop();
    bus_start();
    wr({own, DIR_WRITE}, 1'b0);
    repeat (4) @(posedge clk);
    smci_host_model_inst.sclReg <= 1'b1;
    repeat (150) @(posedge clk);
    check(16'(busy), 16'h0000);
    smci_host_model_inst.sclReg <= 1'b0;
    repeat (4) @(posedge clk);
    bus_stop();
    timeoutEnable <= 1'b0;
    $display("timeout test done");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    t_strap();
    t_write();
    t_read();
    t_alert();
    t_stretch();
    t_timeout();
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
